// ==== common/fpps_pkg.sv ====
// Constants for the flash page program/read sequencer controller.
// Assumes a 100 MHz pclk, an APB3 register port of our own and an 8-bit
// register port into the flash device, synchronous to the same clock.
package fpps_pkg;

  // APB register offsets (one aligned 32-bit word each)
  localparam logic [7:0] OFS_CMD   = 8'h00;
  localparam logic [7:0] OFS_ADDR  = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_BIDX  = 8'h0C;
  localparam logic [7:0] OFS_BDATA = 8'h10;
  localparam logic [7:0] OFS_STAT  = 8'h14;
  localparam logic [7:0] OFS_RDATA = 8'h18;

  // Command register fields
  localparam int CMD_LSB  = 0;
  localparam int CMD_W    = 3;
  localparam int TSEL_BIT = 4;

  typedef enum logic [2:0] {
    CMD_NONE   = 3'h0,
    CMD_UNLOCK = 3'h1,
    CMD_ERASE  = 3'h2,
    CMD_WRITE  = 3'h3,
    CMD_READ   = 3'h4,
    CMD_LOCK   = 3'h5
  } fpps_cmd_t;

  // Status register bits
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERR  = 2;
  localparam int ST_UNLK = 3;
  localparam int ST_TMO  = 4;

  // Device register addresses on its 8-bit register port
  localparam logic [7:0] DEV_CTRL0      = 8'h00;
  localparam logic [7:0] DEV_CTRL2      = 8'h02;
  localparam logic [7:0] DEV_ADDR_LOW   = 8'h03;
  localparam logic [7:0] DEV_ADDR_HIGH  = 8'h04;
  localparam logic [7:0] DEV_DATA_LOW   = 8'h05;
  localparam logic [7:0] DEV_DATA_HIGH  = 8'h06;
  localparam logic [7:0] DEV_PAT1_LOW   = 8'h07;
  localparam logic [7:0] DEV_PAT1_HIGH  = 8'h08;
  localparam logic [7:0] DEV_PAT2_LOW   = 8'h09;
  localparam logic [7:0] DEV_PAT2_HIGH  = 8'h0A;
  localparam logic [7:0] DEV_PAT3_LOW   = 8'h0B;
  localparam logic [7:0] DEV_PAT3_HIGH  = 8'h0C;

  // Control-0 bit positions in the device
  localparam int C0_UNLOCKED  = 7;
  localparam int C0_MODE_LSB  = 4;
  localparam int C0_UNLK_TRIG = 3;
  localparam int C0_WR_TRIG   = 2;
  localparam int C0_RD_EN     = 1;
  localparam int C0_RD_TRIG   = 0;
  // Control-2 bit positions in the device
  localparam int C2_TSEL      = 1;
  localparam int C2_BUF_CLR   = 0;

  // Operation mode field codes
  localparam logic [2:0] MODE_WRITE  = 3'h0;
  localparam logic [2:0] MODE_ERASE  = 3'h1;
  localparam logic [2:0] MODE_READ   = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;

  // Page geometry
  localparam int         FADDR_W    = 14;
  localparam int         PAGE_OFS_W = 5;
  localparam int         CNT_W      = 6;
  localparam logic [5:0] PAGE_WORDS = 6'h20;
  localparam logic [5:0] UNLOCK_LEN = 6'h06;

  // Unlock pattern, first byte in the low lane, paired with its target register
  localparam logic [47:0] UNLOCK_PAT  = 48'h40_09_04_C3_0D_00;
  localparam logic [47:0] UNLOCK_REGS = {DEV_PAT3_HIGH, DEV_PAT2_HIGH, DEV_PAT1_HIGH,
                                         DEV_PAT3_LOW, DEV_PAT2_LOW, DEV_PAT1_LOW};

  // Operation times and the cycle counts derived from them
  localparam int CLK_PERIOD_NS  = 10;
  localparam int ERASE_NORM_US  = 3200;
  localparam int WRITE_NORM_US  = 2200;
  localparam int ERASE_LONG_US  = 3700;
  localparam int WRITE_LONG_US  = 3000;
  localparam int ERASE_NORM_CYC = ERASE_NORM_US * 1000 / CLK_PERIOD_NS;
  localparam int WRITE_NORM_CYC = WRITE_NORM_US * 1000 / CLK_PERIOD_NS;
  localparam int ERASE_LONG_CYC = ERASE_LONG_US * 1000 / CLK_PERIOD_NS;
  localparam int WRITE_LONG_CYC = WRITE_LONG_US * 1000 / CLK_PERIOD_NS;
  localparam int TMO_W          = 21;

endpackage : fpps_pkg

// ==== hw/fpps_page_mem.sv ====
// Page staging memory: one write port, one read port with registered data.
// Assumes both ports run on pclk; read data lags the address by one edge.
`timescale 1ns/1ns
`default_nettype none
module fpps_page_mem #(
  parameter int DW    = 16,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic          pclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_ff
);

  logic [DW-1:0] mem [DEPTH];

  // No reset on the array: contents are always written before use
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge pclk) begin
    rdata_ff <= mem[raddr];
  end

endmodule : fpps_page_mem
`default_nettype wire

// ==== hw/fpps_sequencer.sv ====
// Host-side controller that drives a flash device's IAP register port:
// unlock, page erase, page write and single-word read sequences.
// Assumes the device register port runs on pclk and returns read data one
// cycle after dev_rd_en; software orders it over an APB3 slave.
`timescale 1ns/1ns
`default_nettype none
module fpps_sequencer #(
  parameter int ERASE_NORM_CYC = fpps_pkg::ERASE_NORM_CYC,
  parameter int WRITE_NORM_CYC = fpps_pkg::WRITE_NORM_CYC,
  parameter int ERASE_LONG_CYC = fpps_pkg::ERASE_LONG_CYC,
  parameter int WRITE_LONG_CYC = fpps_pkg::WRITE_LONG_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  dev_addr,
  output logic      [7:0]  dev_wdata,
  output logic             dev_wr_en,
  output logic             dev_rd_en,
  input  wire logic [7:0]  dev_rdata
);

  typedef enum logic [4:0] {
    S_IDLE     = 5'h00,
    S_CTRL2    = 5'h01,
    S_MODE     = 5'h02,
    S_ADDR_L   = 5'h03,
    S_ADDR_H   = 5'h04,
    S_TAG      = 5'h05,
    S_LOAD     = 5'h06,
    S_DATA_L   = 5'h07,
    S_DATA_H   = 5'h08,
    S_PAT      = 5'h09,
    S_TRIG     = 5'h0A,
    S_POLL_REQ = 5'h0B,
    S_POLL_WT  = 5'h0C,
    S_POLL_CHK = 5'h0D,
    S_RD_L     = 5'h0E,
    S_RD_H     = 5'h0F,
    S_CAP_L    = 5'h10,
    S_CAP_H    = 5'h11,
    S_FIN      = 5'h12
  } fpps_state_t;

  // Builds a control-0 value; the unlock flag is written back as held so
  // that ordinary mode writes never drop it by accident
  function automatic logic [7:0] ctrl0(input logic unlk, input logic [2:0] mode,
                                       input logic utrig, input logic wtrig,
                                       input logic ren, input logic rtrig);
    logic [7:0] v;
    v = 8'h00;
    v[fpps_pkg::C0_UNLOCKED] = unlk;
    v[fpps_pkg::C0_MODE_LSB +: 3] = mode;
    v[fpps_pkg::C0_UNLK_TRIG] = utrig;
    v[fpps_pkg::C0_WR_TRIG] = wtrig;
    v[fpps_pkg::C0_RD_EN] = ren;
    v[fpps_pkg::C0_RD_TRIG] = rtrig;
    return v;
  endfunction : ctrl0

  fpps_state_t              state_ff, nxt_state;
  fpps_pkg::fpps_cmd_t      cmd_ff;
  logic                     tsel_ff;
  logic                     start_ff;
  logic [fpps_pkg::FADDR_W-1:0] addr_ff, op_addr_ff;
  logic [fpps_pkg::CNT_W-1:0]   count_ff, op_count_ff;
  logic [fpps_pkg::PAGE_OFS_W-1:0] bidx_ff;
  logic [fpps_pkg::CNT_W-1:0]   cnt_ff, nxt_cnt;
  logic [fpps_pkg::TMO_W-1:0]   tmo_ff, tmo_limit;
  logic [7:0]               poll_mask_ff;
  logic                     done_ff, err_ff, tmo_err_ff, unlocked_ff;
  logic [15:0]              rdata_ff;
  logic [7:0]               dev_addr_ff, nxt_addr;
  logic [7:0]               dev_wdata_ff, nxt_wdata;
  logic                     dev_wr_ff, nxt_wr, dev_rd_ff, nxt_rd;
  logic [31:0]              prdata_ff;
  logic                     apb_wr, mem_we;
  logic [15:0]              mem_rdata;
  logic                     busy;
  logic                     refuse;
  logic [fpps_pkg::CNT_W:0] span;

  assign busy      = (state_ff != S_IDLE);
  assign apb_wr    = psel & penable & pwrite;
  assign mem_we    = apb_wr & (paddr == fpps_pkg::OFS_BDATA);
  assign pready    = 1'b1;
  assign prdata    = prdata_ff;
  assign dev_addr  = dev_addr_ff;
  assign dev_wdata = dev_wdata_ff;
  assign dev_wr_en = dev_wr_ff;
  assign dev_rd_en = dev_rd_ff;

  // Unmapped offsets answer with an error in the access phase
  always_comb begin
    case (paddr)
      fpps_pkg::OFS_CMD, fpps_pkg::OFS_ADDR, fpps_pkg::OFS_COUNT, fpps_pkg::OFS_BIDX,
      fpps_pkg::OFS_BDATA, fpps_pkg::OFS_STAT, fpps_pkg::OFS_RDATA: pslverr = 1'b0;
      default: pslverr = psel & penable;
    endcase
  end

  // Read data is latched in the setup phase so it stands through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      prdata_ff <= 32'h0000_0000;
      case (paddr)
        fpps_pkg::OFS_CMD: begin
          prdata_ff[fpps_pkg::CMD_LSB +: fpps_pkg::CMD_W] <= cmd_ff;
          prdata_ff[fpps_pkg::TSEL_BIT] <= tsel_ff;
        end
        fpps_pkg::OFS_ADDR:  prdata_ff[fpps_pkg::FADDR_W-1:0] <= addr_ff;
        fpps_pkg::OFS_COUNT: prdata_ff[fpps_pkg::CNT_W-1:0] <= count_ff;
        fpps_pkg::OFS_BIDX:  prdata_ff[fpps_pkg::PAGE_OFS_W-1:0] <= bidx_ff;
        fpps_pkg::OFS_STAT: begin
          prdata_ff[fpps_pkg::ST_BUSY] <= busy;
          prdata_ff[fpps_pkg::ST_DONE] <= done_ff;
          prdata_ff[fpps_pkg::ST_ERR]  <= err_ff;
          prdata_ff[fpps_pkg::ST_UNLK] <= unlocked_ff;
          prdata_ff[fpps_pkg::ST_TMO]  <= tmo_err_ff;
        end
        fpps_pkg::OFS_RDATA: prdata_ff[15:0] <= rdata_ff;
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Command register; a new command is only accepted while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ff   <= fpps_pkg::CMD_NONE;
      tsel_ff  <= 1'b0;
      start_ff <= 1'b0;
    end else begin
      start_ff <= 1'b0;
      if (apb_wr && paddr == fpps_pkg::OFS_CMD && !busy && !start_ff) begin
        cmd_ff   <= fpps_pkg::fpps_cmd_t'(pwdata[fpps_pkg::CMD_LSB +: fpps_pkg::CMD_W]);
        tsel_ff  <= pwdata[fpps_pkg::TSEL_BIT];
        start_ff <= (pwdata[fpps_pkg::CMD_LSB +: fpps_pkg::CMD_W] != fpps_pkg::CMD_NONE);
      end
    end
  end

  // Address, count and staging index; the stage index wraps so a full page
  // of 32 loads always lands in order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_ff  <= '0;
      count_ff <= fpps_pkg::PAGE_WORDS;
      bidx_ff  <= '0;
    end else if (apb_wr) begin
      if (paddr == fpps_pkg::OFS_ADDR) addr_ff <= pwdata[fpps_pkg::FADDR_W-1:0];
      if (paddr == fpps_pkg::OFS_COUNT) count_ff <= pwdata[fpps_pkg::CNT_W-1:0];
      if (paddr == fpps_pkg::OFS_BIDX) bidx_ff <= pwdata[fpps_pkg::PAGE_OFS_W-1:0];
      if (paddr == fpps_pkg::OFS_BDATA) bidx_ff <= bidx_ff + 1'b1;
    end
  end

  // Word staging for one page program
  fpps_page_mem #(
    .DW    (16),
    .DEPTH (32),
    .AW    (fpps_pkg::PAGE_OFS_W)
  ) u_page_mem (
    .pclk     (pclk),
    .we       (mem_we),
    .waddr    (bidx_ff),
    .wdata    (pwdata[15:0]),
    .raddr    (cnt_ff[fpps_pkg::PAGE_OFS_W-1:0]),
    .rdata_ff (mem_rdata)
  );

  // Writes that would cross the page end, or erase/write while locked,
  // are refused before any device access
  assign span   = {1'b0, addr_ff[fpps_pkg::PAGE_OFS_W-1:0]} + {1'b0, count_ff};
  always_comb begin
    refuse = 1'b0;
    if ((cmd_ff == fpps_pkg::CMD_ERASE || cmd_ff == fpps_pkg::CMD_WRITE) && !unlocked_ff)
      refuse = 1'b1;
    if (cmd_ff == fpps_pkg::CMD_WRITE &&
        (count_ff == '0 || count_ff > fpps_pkg::PAGE_WORDS ||
         span > {1'b0, fpps_pkg::PAGE_WORDS}))
      refuse = 1'b1;
  end

  // Poll limit: twice the selected device time; counts assume full-speed pclk
  always_comb begin
    if (cmd_ff == fpps_pkg::CMD_ERASE)
      tmo_limit = fpps_pkg::TMO_W'(2 * (tsel_ff ? ERASE_LONG_CYC : ERASE_NORM_CYC));
    else
      tmo_limit = fpps_pkg::TMO_W'(2 * (tsel_ff ? WRITE_LONG_CYC : WRITE_NORM_CYC));
  end

  // Sequencer: each state issues at most one device register access
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_wr    = 1'b0;
    nxt_rd    = 1'b0;
    nxt_addr  = dev_addr_ff;
    nxt_wdata = dev_wdata_ff;
    case (state_ff)
      S_IDLE: begin
        nxt_cnt = '0;
        if (start_ff && !refuse) begin
          if (cmd_ff == fpps_pkg::CMD_ERASE || cmd_ff == fpps_pkg::CMD_WRITE)
            nxt_state = S_CTRL2;
          else
            nxt_state = S_MODE;
        end
      end
      S_CTRL2: begin
        // Clear the device buffer first, so a retry reloads from empty
        nxt_wr    = 1'b1;
        nxt_addr  = fpps_pkg::DEV_CTRL2;
        nxt_wdata = 8'h00;
        nxt_wdata[fpps_pkg::C2_BUF_CLR] = 1'b1;
        nxt_wdata[fpps_pkg::C2_TSEL] = tsel_ff;
        nxt_state = S_MODE;
      end
      S_MODE: begin
        nxt_wr   = 1'b1;
        nxt_addr = fpps_pkg::DEV_CTRL0;
        case (cmd_ff)
          fpps_pkg::CMD_UNLOCK: begin
            nxt_wdata = ctrl0(unlocked_ff, fpps_pkg::MODE_UNLOCK, 1'b1, 1'b0, 1'b0, 1'b0);
            nxt_state = S_PAT;
          end
          fpps_pkg::CMD_ERASE: begin
            nxt_wdata = ctrl0(1'b1, fpps_pkg::MODE_ERASE, 1'b0, 1'b0, 1'b0, 1'b0);
            nxt_state = S_ADDR_L;
          end
          fpps_pkg::CMD_WRITE: begin
            nxt_wdata = ctrl0(1'b1, fpps_pkg::MODE_WRITE, 1'b0, 1'b0, 1'b0, 1'b0);
            nxt_state = S_ADDR_L;
          end
          fpps_pkg::CMD_READ: begin
            // Enable first; the S_TRIG write then sets the trigger with enable still held
            nxt_wdata = ctrl0(unlocked_ff, fpps_pkg::MODE_READ, 1'b0, 1'b0, 1'b1, 1'b0);
            nxt_state = S_ADDR_L;
          end
          default: begin
            nxt_wdata = ctrl0(1'b0, fpps_pkg::MODE_WRITE, 1'b0, 1'b0, 1'b0, 1'b0);
            nxt_state = S_FIN;
          end
        endcase
      end
      S_ADDR_L: begin
        nxt_wr    = 1'b1;
        nxt_addr  = fpps_pkg::DEV_ADDR_LOW;
        nxt_wdata = op_addr_ff[7:0];
        if (cmd_ff == fpps_pkg::CMD_ERASE)
          nxt_wdata[fpps_pkg::PAGE_OFS_W-1:0] = '0;
        nxt_state = S_ADDR_H;
      end
      S_ADDR_H: begin
        nxt_wr    = 1'b1;
        nxt_addr  = fpps_pkg::DEV_ADDR_HIGH;
        nxt_wdata = 8'(op_addr_ff[fpps_pkg::FADDR_W-1:8]);
        if (cmd_ff == fpps_pkg::CMD_ERASE)
          nxt_state = S_TAG;
        else if (cmd_ff == fpps_pkg::CMD_WRITE)
          nxt_state = S_LOAD;
        else
          nxt_state = S_TRIG;
      end
      S_TAG: begin
        // Dummy high-byte writes tag every word of the page
        nxt_wr    = 1'b1;
        nxt_addr  = fpps_pkg::DEV_DATA_HIGH;
        nxt_wdata = 8'h00;
        nxt_cnt   = cnt_ff + 1'b1;
        if (nxt_cnt == fpps_pkg::PAGE_WORDS)
          nxt_state = S_TRIG;
      end
      S_LOAD: begin
        // One idle cycle lets the staging memory present the next word
        nxt_state = S_DATA_L;
      end
      S_DATA_L: begin
        nxt_wr    = 1'b1;
        nxt_addr  = fpps_pkg::DEV_DATA_LOW;
        nxt_wdata = mem_rdata[7:0];
        nxt_state = S_DATA_H;
      end
      S_DATA_H: begin
        nxt_wr    = 1'b1;
        nxt_addr  = fpps_pkg::DEV_DATA_HIGH;
        nxt_wdata = mem_rdata[15:8];
        nxt_cnt   = cnt_ff + 1'b1;
        if (nxt_cnt == op_count_ff)
          nxt_state = S_TRIG;
        else
          nxt_state = S_LOAD;
      end
      S_PAT: begin
        nxt_wr    = 1'b1;
        nxt_addr  = fpps_pkg::UNLOCK_REGS[cnt_ff*8 +: 8];
        nxt_wdata = fpps_pkg::UNLOCK_PAT[cnt_ff*8 +: 8];
        nxt_cnt   = cnt_ff + 1'b1;
        if (nxt_cnt == fpps_pkg::UNLOCK_LEN)
          nxt_state = S_POLL_REQ;
      end
      S_TRIG: begin
        nxt_wr   = 1'b1;
        nxt_addr = fpps_pkg::DEV_CTRL0;
        if (cmd_ff == fpps_pkg::CMD_ERASE)
          nxt_wdata = ctrl0(1'b1, fpps_pkg::MODE_ERASE, 1'b0, 1'b1, 1'b0, 1'b0);
        else if (cmd_ff == fpps_pkg::CMD_WRITE)
          nxt_wdata = ctrl0(1'b1, fpps_pkg::MODE_WRITE, 1'b0, 1'b1, 1'b0, 1'b0);
        else
          nxt_wdata = ctrl0(unlocked_ff, fpps_pkg::MODE_READ, 1'b0, 1'b0, 1'b1, 1'b1);
        nxt_state = S_POLL_REQ;
      end
      S_POLL_REQ: begin
        // The device core is stalled meanwhile; only its port answers
        nxt_rd    = 1'b1;
        nxt_addr  = fpps_pkg::DEV_CTRL0;
        nxt_state = S_POLL_WT;
      end
      S_POLL_WT: nxt_state = S_POLL_CHK;
      S_POLL_CHK: begin
        if ((dev_rdata & poll_mask_ff) == 8'h00) begin
          if (cmd_ff == fpps_pkg::CMD_READ)
            nxt_state = S_RD_L;
          else
            nxt_state = S_FIN;
        end else if (tmo_ff >= tmo_limit) begin
          nxt_state = S_FIN;
        end else begin
          nxt_state = S_POLL_REQ;
        end
      end
      S_RD_L: begin
        nxt_rd    = 1'b1;
        nxt_addr  = fpps_pkg::DEV_DATA_LOW;
        nxt_state = S_RD_H;
      end
      S_RD_H: begin
        nxt_rd    = 1'b1;
        nxt_addr  = fpps_pkg::DEV_DATA_HIGH;
        nxt_state = S_CAP_L;
      end
      S_CAP_L: nxt_state = S_CAP_H;
      S_CAP_H: nxt_state = S_FIN;
      S_FIN:   nxt_state = S_IDLE;
      default: nxt_state = S_IDLE;
    endcase
  end

  // State and device port flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff     <= S_IDLE;
      cnt_ff       <= '0;
      dev_addr_ff  <= 8'h00;
      dev_wdata_ff <= 8'h00;
      dev_wr_ff    <= 1'b0;
      dev_rd_ff    <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      dev_addr_ff  <= nxt_addr;
      dev_wdata_ff <= nxt_wdata;
      dev_wr_ff    <= nxt_wr;
      dev_rd_ff    <= nxt_rd;
    end
  end

  // Address and count snapshot, so APB writes to them during a run cannot disturb it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_addr_ff   <= '0;
      op_count_ff  <= '0;
      poll_mask_ff <= 8'h00;
    end else if (state_ff == S_IDLE && start_ff) begin
      op_addr_ff  <= addr_ff;
      op_count_ff <= count_ff;
      case (cmd_ff)
        fpps_pkg::CMD_UNLOCK: poll_mask_ff <= 8'(1) << fpps_pkg::C0_UNLK_TRIG;
        fpps_pkg::CMD_READ:   poll_mask_ff <= 8'(1) << fpps_pkg::C0_RD_TRIG;
        default:              poll_mask_ff <= 8'(1) << fpps_pkg::C0_WR_TRIG;
      endcase
    end
  end

  // Poll watchdog; runs only while waiting on a trigger bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_ff <= '0;
    end else if (state_ff == S_IDLE) begin
      tmo_ff <= '0;
    end else if (state_ff == S_POLL_REQ || state_ff == S_POLL_WT || state_ff == S_POLL_CHK) begin
      if (tmo_ff != {fpps_pkg::TMO_W{1'b1}}) tmo_ff <= tmo_ff + 1'b1;
    end
  end

  // Status: cleared on an accepted command, set at once on a refused one, else set as the run ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_ff     <= 1'b0;
      err_ff      <= 1'b0;
      tmo_err_ff  <= 1'b0;
      unlocked_ff <= 1'b0;
    end else begin
      if (state_ff == S_IDLE && start_ff) begin
        done_ff    <= refuse;
        err_ff     <= refuse;
        tmo_err_ff <= 1'b0;
      end
      if (state_ff == S_POLL_CHK && (dev_rdata & poll_mask_ff) == 8'h00)
        unlocked_ff <= dev_rdata[fpps_pkg::C0_UNLOCKED];
      if (state_ff == S_POLL_CHK && (dev_rdata & poll_mask_ff) != 8'h00 &&
          tmo_ff >= tmo_limit) begin
        err_ff     <= 1'b1;
        tmo_err_ff <= 1'b1;
      end
      if (state_ff == S_MODE && cmd_ff == fpps_pkg::CMD_LOCK)
        unlocked_ff <= 1'b0;
      if (state_ff == S_FIN)
        done_ff <= 1'b1;
    end
  end

  // Read word capture, low byte then high byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 16'h0000;
    end else if (state_ff == S_CAP_L) begin
      rdata_ff[7:0] <= dev_rdata;
    end else if (state_ff == S_CAP_H) begin
      rdata_ff[15:8] <= dev_rdata;
    end
  end

endmodule : fpps_sequencer
`default_nettype wire

// ==== tb/fpps_seq_asserts.sv ====
// Checker: APB answer and device-port sequences of the sequencer.
// Bound to fpps_sequencer; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module fpps_seq_asserts (
  input wire logic       pclk, presetn, psel, penable, pslverr, dev_wr_en, dev_rd_en,
  input wire logic [7:0] paddr, dev_addr, dev_wdata);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [16:0] wv;
  logic [5:0]  tags_ff;
  assign wv = {dev_wr_en, dev_addr, dev_wdata};
  // Tag writes since the last control write; an erase needs a full page
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) tags_ff <= 6'h00;
    else if (wv[16:8] == 9'h100) tags_ff <= 6'h00;
    else if (wv[16:8] == 9'h106) tags_ff <= tags_ff + 6'h01;
  unmapped_err_a: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
    else $error("unmapped access without pslverr");
  locked_gate_a: assert property (wv[16:8] == 9'h100 && wv[2] |-> wv[7])
    else $error("erase or write trigger while locked");
  read_setup_a: assert property (wv[16:8] == 9'h100 && wv[0] |-> wv[6:1] == 6'h19)
    else $error("read trigger without read mode and enable");
  whole_page_a: assert property (wv == 17'h10094 |-> tags_ff == 6'h20)
    else $error("erase started without 32 tags");
  word_pair_a: assert property (wv[16:8] == 9'h105 |=> wv[16:8] == 9'h106)
    else $error("low byte not followed by high byte");
  clear_first_a: assert property (wv[16:8] == 9'h102 |-> wv[0])
    else $error("buffer not cleared");
  read_pair_a: assert property (dev_rd_en && dev_addr == 8'h05 |=> dev_addr == 8'h06)
    else $error("read data not fetched in pair");
  pattern_order_a: assert property (wv[16:8] == 9'h107 |-> wv[7:0] == 8'h00
    ##1 wv == 17'h1090D ##1 wv == 17'h10BC3 ##1 wv == 17'h10804 ##1 wv == 17'h10A09
    ##1 wv == 17'h10C40) else $error("unlock pattern out of order");
endmodule : fpps_seq_asserts
bind fpps_sequencer fpps_seq_asserts i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pslverr(pslverr), .dev_wr_en(dev_wr_en), .dev_rd_en(dev_rd_en),
  .paddr(paddr), .dev_addr(dev_addr), .dev_wdata(dev_wdata));
`default_nettype wire

// ==== tb/fpps_flash_model.sv ====
// Flash device model: control, address, data and pattern registers, page buffer.
// Assumes the host strobes its register port on pclk; times are shortened.
`timescale 1ns/1ns
`default_nettype none
module fpps_flash_model (
  input  wire logic       pclk, presetn, dev_wr_en, dev_rd_en,
  input  wire logic [7:0] dev_addr, dev_wdata,
  output logic      [7:0] dev_rdata);
  logic [7:0]  r [0:12];
  logic [15:0] mem [0:16383];
  logic [15:0] wbuf [0:31];
  logic [13:0] fa;
  logic [7:0]  d;
  int          tmr;
  assign fa = {r[4][5:0], r[3]}; // Page bits are fa[13:5]
  // Not blank at start, so an erase is visible
  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    foreach (wbuf[i]) wbuf[i] = 16'h0000;
  end
  // Register file; triggers fall back when their timer runs out
  always @(posedge pclk or negedge presetn) begin
    d = dev_wdata;
    if (!presetn) begin
      foreach (r[i]) r[i] = 8'h00;
      tmr = 0;
      dev_rdata <= 8'h00;
    end else begin
      dev_rdata <= dev_rd_en ? r[dev_addr] : ~dev_rdata; // Idle lane toggles
      if (tmr == 1) r[0] = r[0] & 8'hF2;
      if (tmr > 0) tmr--;
      if (dev_wr_en) case (dev_addr)
        8'h00: begin
          r[0] = {r[0][7] & d[7], d[6:0]};
          if (d[2] && !r[0][7]) r[0][2] = 1'b0; // Refused while locked
          else if (d[2] && d[6:4] == 3'h1) begin
            for (int i = 0; i < 32; i++) mem[{fa[13:5], i[4:0]}] = 16'h0000;
            tmr = r[2][1] ? 16 : 12;
          end else if (d[2]) begin
            for (int i = 0; i < 32; i++) mem[{fa[13:5], i[4:0]}] |= wbuf[i];
            tmr = r[2][1] ? 14 : 10;
          end
          if (d[3]) tmr = 8;
          if (d[1:0] == 2'h3 && d[6:4] == 3'h3) begin
            {r[6], r[5]} = mem[fa];
            tmr = 3;
          end
        end
        8'h02: begin
          r[2] = d & 8'h02;
          if (d[0]) foreach (wbuf[i]) wbuf[i] = 16'h0000;
        end
        8'h06: begin
          wbuf[r[3][4:0]] = {d, r[5]};
          if (r[3][4:0] != 5'h1F) r[3] = r[3] + 8'h01;
        end
        8'h0C: if (r[0][6:3] == 4'hD && {r[7], r[9], r[11], r[8], r[10], d} == 48'h000DC3040940)
          r[0][7] = 1'b1;
        default: r[dev_addr] = d;
      endcase
    end
  end
endmodule : fpps_flash_model
`default_nettype wire

// ==== tb/fpps_sequencer_bench.sv ====
// Bench for the sequencer: APB master tasks, scenarios and verdict.
// Assumes the flash model on the device port and shortened op times.
`timescale 1ns/1ns
`default_nettype none
module fpps_sequencer_bench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, dev_wr_en, dev_rd_en, err_seen;
  logic [7:0]  paddr = 8'h00, dev_addr, dev_wdata, dev_rdata;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int          error_cnt = 0, comparisons = 0, cyc = 0;
  fpps_sequencer #(.ERASE_NORM_CYC(20), .WRITE_NORM_CYC(15), .ERASE_LONG_CYC(25),
                   .WRITE_LONG_CYC(20)) i_dut (.*);
  fpps_flash_model i_flash (.*);
  initial forever #5 pclk = ~pclk;
  // Hang guard; the run needs a few hundred cycles
  always @(posedge pclk) if (++cyc == 20000) begin
    error_cnt++;
    report_and_stop();
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Request holds until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic op(input logic [31:0] c, input logic [31:0] st);
    apb(1'b1, fpps_pkg::OFS_CMD, c);
    rd = 32'h0;
    repeat (100) if (rd[1] !== 1'b1) apb(1'b0, fpps_pkg::OFS_STAT, 32'h0);
    chk("status", st, rd);
  endtask : op
  // Address is reloaded for every word read
  task automatic rdw(input logic [13:0] a, input logic [15:0] e, input logic [31:0] st);
    apb(1'b1, fpps_pkg::OFS_ADDR, {18'h0, a});
    op(fpps_pkg::CMD_READ, st);
    apb(1'b0, fpps_pkg::OFS_RDATA, 32'h0);
    chk("word", {16'h0, e}, rd);
  endtask : rdw
  task automatic t_idle;
    apb(1'b0, fpps_pkg::OFS_COUNT, 32'h0);
    chk("count", 32'h20, rd);
    apb(1'b0, 8'h1C, 32'h0);
    chk("slverr", 32'h1, {31'h0, err_seen});
    op(fpps_pkg::CMD_ERASE, 32'h6);
    $display("test idle done");
  endtask : t_idle
  task automatic t_erase;
    op(fpps_pkg::CMD_UNLOCK, 32'hA);
    apb(1'b1, fpps_pkg::OFS_ADDR, 32'h47);
    op(32'h12, 32'hA);
    chk("tsel", 32'h2, {24'h0, i_flash.r[2]});
    rdw(14'h5F, 16'h0000, 32'hA);
    rdw(14'h60, 16'hFFFF, 32'hA);
    $display("test erase done");
  endtask : t_erase
  task automatic t_write;
    apb(1'b1, fpps_pkg::OFS_BIDX, 32'h0);
    apb(1'b1, fpps_pkg::OFS_BDATA, 32'h1234);
    apb(1'b1, fpps_pkg::OFS_BDATA, 32'hABCD);
    apb(1'b1, fpps_pkg::OFS_COUNT, 32'h2);
    apb(1'b1, fpps_pkg::OFS_ADDR, 32'h5E);
    op(fpps_pkg::CMD_WRITE, 32'hA);
    chk("tsel", 32'h0, {24'h0, i_flash.r[2]});
    rdw(14'h5E, 16'h1234, 32'hA);
    rdw(14'h5F, 16'hABCD, 32'hA);
    apb(1'b1, fpps_pkg::OFS_COUNT, 32'h3);
    op(fpps_pkg::CMD_WRITE, 32'hE);
    $display("test write done");
  endtask : t_write
  task automatic t_lock;
    apb(1'b1, fpps_pkg::OFS_COUNT, 32'h2);
    op(fpps_pkg::CMD_LOCK, 32'h2);
    op(fpps_pkg::CMD_WRITE, 32'h6);
    rdw(14'h5E, 16'h1234, 32'h2);
    $display("test lock done");
  endtask : t_lock
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_idle();
    t_erase();
    t_write();
    t_lock();
    report_and_stop();
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
endmodule : fpps_sequencer_bench
`default_nettype wire
